// ==== data_memory_bank_stack_decode_tb.sv ====
// Purpose: Directed scenarios for the data memory decode block
// Assumes: One request at a time, driven at the falling edge
// Notes:   Only occupied peripheral addresses are touched
`timescale 1ns/1ps
`default_nettype none
module data_memory_bank_stack_decode_tb;
    import dmb_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       req_valid = 1'b0;
    dmb_req_s   req = '0;
    logic       rsp_valid, rsp_bit;
    logic [7:0] rsp_data, sp, processor_status_word, sfr_rdata;
    logic [1:0] bank;
    dmb_sfr_s   sfr;
    int         failures = 0;
    int         checks_done = 0;
    dmb_decode DUT (.core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_bit(rsp_bit), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .stack_top_pointer_q(sp), .processor_status_word_q(processor_status_word), .active_bank(bank));
    dmb_sfr_model PEER (.core_clk(core_clk), .sfr(sfr), .sfr_rdata(sfr_rdata));
    initial forever #2.5 core_clk = ~core_clk;
    task automatic complete_run;
        if (failures == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic xfer(input dmb_op_e op, input logic b, input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        int n;
        @(negedge core_clk);
        req = '{op, b, w, a, d[0], d};
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        for (n = 0; n < 10; n++) begin
            @(negedge core_clk);
            if (rsp_valid === 1'b1) break;
        end
        if (n == 10) check("response", 8'h00, 8'h01);
    endtask
    task automatic t_stack;
        check("sp reset", sp, 8'h07);
        check("psw reset", processor_status_word, 8'h00);
        xfer(DMB_OP_PUSH, 0, 1, 8'h00, 8'hc3);
        check("sp push", sp, 8'h08);
        xfer(DMB_OP_DIRECT, 0, 0, 8'h08, 8'h00);
        check("bank1 r0", rsp_data, 8'hc3);
        xfer(DMB_OP_POP, 0, 0, 8'h00, 8'h00);
        check("pop data", rsp_data, 8'hc3);
        check("sp pop", sp, 8'h07);
        xfer(DMB_OP_DIRECT, 0, 1, 8'h81, 8'hff);
        xfer(DMB_OP_DIRECT, 0, 0, 8'h81, 8'h00);
        check("sp read", rsp_data, 8'hff);
        xfer(DMB_OP_PUSH, 0, 1, 8'h00, 8'h3c);
        check("sp wrap", sp, 8'h00);
        xfer(DMB_OP_DIRECT, 0, 0, 8'h00, 8'h00);
        check("wrap data", rsp_data, 8'h3c);
        xfer(DMB_OP_POP, 0, 0, 8'h00, 8'h00);
        check("sp unwrap", sp, 8'hff);
    endtask
    task automatic t_banks;
        for (int b = 0; b < 4; b++) begin
            xfer(DMB_OP_DIRECT, 0, 1, 8'hd0, 8'(b << 3));
            check("bank", {6'h00, bank}, 8'(b));
            xfer(DMB_OP_RN, 0, 1, 8'h03, 8'h10 + 8'(b));
        end
        for (int b = 0; b < 4; b++) begin
            xfer(DMB_OP_DIRECT, 0, 0, 8'(b * 8 + 3), 8'h00);
            check("bank r3", rsp_data, 8'h10 + 8'(b));
        end
    endtask
    task automatic t_indirect;
        xfer(DMB_OP_DIRECT, 0, 1, 8'hd0, 8'h10);
        xfer(DMB_OP_RN, 0, 1, 8'h01, 8'h30);
        xfer(DMB_OP_INDIRECT, 0, 1, 8'h01, 8'h5a);
        xfer(DMB_OP_DIRECT, 0, 0, 8'h30, 8'h00);
        check("ind low", rsp_data, 8'h5a);
        xfer(DMB_OP_RN, 0, 1, 8'h00, 8'h90);
        xfer(DMB_OP_INDIRECT, 0, 1, 8'h00, 8'ha5);
        xfer(DMB_OP_INDIRECT, 0, 0, 8'h00, 8'h00);
        check("ind upper", rsp_data, 8'ha5);
        check("sfr kept", PEER.mem[8'h90], 8'h90);
        xfer(DMB_OP_DIRECT, 0, 0, 8'h90, 8'h00);
        check("direct sfr", rsp_data, 8'h90);
    endtask
    task automatic t_bits;
        xfer(DMB_OP_DIRECT, 0, 1, 8'h22, 8'h00);
        xfer(DMB_OP_DIRECT, 1, 1, 8'h13, 8'h01);
        xfer(DMB_OP_DIRECT, 0, 0, 8'h22, 8'h00);
        check("bit 22.3", rsp_data, 8'h08);
        xfer(DMB_OP_DIRECT, 1, 0, 8'h13, 8'h00);
        check("bit read", {7'h00, rsp_bit}, 8'h01);
        xfer(DMB_OP_DIRECT, 0, 1, 8'h2f, 8'h00);
        xfer(DMB_OP_DIRECT, 1, 1, 8'h7f, 8'h01);
        xfer(DMB_OP_DIRECT, 0, 0, 8'h2f, 8'h00);
        check("bit 7f", rsp_data, 8'h80);
        // Occupied peripheral addresses only
        xfer(DMB_OP_DIRECT, 0, 1, 8'h90, 8'h00);
        xfer(DMB_OP_DIRECT, 1, 1, 8'h93, 8'h01);
        check("sfr bit", PEER.mem[8'h90], 8'h08);
        xfer(DMB_OP_DIRECT, 1, 0, 8'h93, 8'h00);
        check("sfr bit read", {7'h00, rsp_bit}, 8'h01);
        xfer(DMB_OP_DIRECT, 0, 0, 8'hd0, 8'h00);
        check("psw read", rsp_data, 8'h10);
        xfer(DMB_OP_DIRECT, 0, 1, 8'h99, 8'h77);
        check("sfr byte", PEER.mem[8'h99], 8'h77);
    endtask
    initial begin
        #100us;
        failures++;
        complete_run();
    end
    initial begin
        repeat (16) @(negedge core_clk);
        rst_b = 1'b1;
        t_stack();
        t_banks();
        t_indirect();
        t_bits();
        complete_run();
    end
endmodule // data_memory_bank_stack_decode_tb
`default_nettype wire

// ==== dmb_decode.sv ====
// Purpose: Data memory, register bank, bit region, stack and SFR steering
// Assumes: Requests are single-cycle strobes; the next request waits for rsp_valid
// Notes:   Read-modify-write for bit writes and PROCESSOR_STATUS_WORD/SP held locally
`timescale 1ns/1ps
`default_nettype none
`include "dmb_defs.svh"

// Overview of operation
// - Bytes 0x00-0x1F are four eight-register banks
// - PROCESSOR_STATUS_WORD bits 3,4 select one bank
// - Indirect pointer from R0/R1 of bank
// - Bytes 0x20-0x2F also 128 bits
// - Bit address: byte 0x20+n/8, bit n%8
// - Bit or byte from instruction operand
// - Stack pointer at 0x81 marks top
// - Push writes SP+1 and increments SP on the same edge
// - Reset loads stack pointer with 0x07
// - Stack pointer arithmetic wraps on 8 bits
// - Direct 0x80-0xFF goes to SFRs
// - Only SFRs at x0/x8 bit addressable
// - Indirect above 0x7F reaches upper RAM
// - Lower 128 bytes direct and indirect
module dmb_decode
    import dmb_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       req_valid,
    input  wire dmb_req_s   req,
    output logic            rsp_valid,
    output logic      [7:0] rsp_data,
    output logic            rsp_bit,
    output dmb_sfr_s        sfr,
    input  wire logic [7:0] sfr_rdata,
    output logic      [7:0] stack_top_pointer_q,
    output logic      [7:0] processor_status_word_q,
    output logic      [1:0] active_bank
);
    typedef enum logic [1:0] {
        DMB_ST_IDLE  = 2'b00,
        DMB_ST_PTR   = 2'b01,
        DMB_ST_READ  = 2'b10,
        DMB_ST_WRITE = 2'b11
    } dmb_st_e;

    dmb_st_e    st_q;
    dmb_st_e    st_d;
    dmb_req_s   cur_q;
    logic [7:0] eaddr_q;
    logic [7:0] eaddr_d;
    logic [2:0] bitpos_q;
    logic [2:0] bitpos_d;
    logic       to_sfr_q;
    logic       to_sfr_d;
    logic       ram_we;
    logic [7:0] ram_waddr;
    logic [7:0] ram_wdata;
    logic [7:0] ram_raddr;
    logic [7:0] ram_rdata;
    logic [7:0] byte_rd;
    logic [7:0] byte_wr;
    logic       local_hit;
    logic [7:0] local_rd;
    logic       done;
    logic [7:0] ptr_addr;
    logic [7:0] sfr_bitaddr;
    logic [7:0] bit_sel;
    logic [7:0] bit_merged;
    logic       needs_write;
    logic       is_push;
    logic       is_pop;
    logic       req_take;

    assign active_bank = {processor_status_word_q[`DMB_RS1_POS],
                          processor_status_word_q[`DMB_RS0_POS]};

    // Register n of active bank is bank*8+n
    assign ptr_addr    = {3'b000, active_bank, 2'b00, req.addr[0]};

    assign sfr_bitaddr = req.addr & ~`DMB_SFR_BITMASK;

    // Decoded kind of the captured request
    assign is_push     = (cur_q.op == DMB_OP_PUSH);
    assign is_pop      = (cur_q.op == DMB_OP_POP);
    assign needs_write = cur_q.wr && !is_pop;

    // Address and target resolution for the first cycle
    always_comb begin
        eaddr_d  = req.addr;
        bitpos_d = req.addr[2:0];
        to_sfr_d = 1'b0;
        st_d     = DMB_ST_READ;
        case (req.op)
            DMB_OP_DIRECT: begin
                if (req.is_bit) begin
                    if (req.addr < `DMB_BITADR_SFR) begin
                        eaddr_d = `DMB_BITRAM_BASE + {3'b000, req.addr[7:3]};
                    end else begin
                        eaddr_d  = sfr_bitaddr;
                        to_sfr_d = 1'b1;
                    end
                end else begin
                    to_sfr_d = (req.addr >= `DMB_SFR_BASE);
                end
            end
            DMB_OP_INDIRECT: begin
                eaddr_d = ptr_addr;
                st_d    = DMB_ST_PTR;
            end
            DMB_OP_RN: begin
                eaddr_d = {3'b000, active_bank, req.addr[2:0]};
            end
            DMB_OP_PUSH: begin
                eaddr_d = stack_top_pointer_q + `DMB_ONE;
                st_d    = DMB_ST_WRITE;
            end
            DMB_OP_POP: begin
                eaddr_d = stack_top_pointer_q;
            end
            default: begin
                st_d = DMB_ST_IDLE;
            end
        endcase
    end

    // Sequencer: PTR fetches pointer, READ returns or modifies, WRITE stores
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= DMB_ST_IDLE;
        end else begin
            case (st_q)
                DMB_ST_IDLE: begin
                    if (req_valid) begin
                        // Push needs no merge read
                        st_q <= (req.op == DMB_OP_PUSH && !to_sfr_d) ? DMB_ST_WRITE : st_d;
                    end
                end
                DMB_ST_PTR: begin
                    st_q <= DMB_ST_READ;
                end
                DMB_ST_READ: begin
                    st_q <= needs_write ? DMB_ST_WRITE : DMB_ST_IDLE;
                end
                DMB_ST_WRITE: begin
                    st_q <= DMB_ST_IDLE;
                end
                default: begin
                    st_q <= DMB_ST_IDLE;
                end
            endcase
        end
    end

    assign req_take = (st_q == DMB_ST_IDLE) && req_valid;

    // Request and target captured at take
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_q    <= '0;
            bitpos_q <= '0;
            to_sfr_q <= 1'b0;
        end else if (req_take) begin
            cur_q    <= req;
            bitpos_q <= bitpos_d;
            to_sfr_q <= to_sfr_d;
        end
    end

    // Effective address; indirect replaces it by the fetched pointer
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            eaddr_q <= '0;
        end else if (req_take) begin
            eaddr_q <= eaddr_d;
        end else if (st_q == DMB_ST_PTR) begin
            eaddr_q <= ram_rdata;
        end
    end

    // Read port: request address, then fetched pointer, then held address
    always_comb begin
        case (st_q)
            DMB_ST_IDLE: begin
                ram_raddr = eaddr_d;
            end
            DMB_ST_PTR: begin
                ram_raddr = ram_rdata;
            end
            default: begin
                ram_raddr = eaddr_q;
            end
        endcase
    end

    // SP and PROCESSOR_STATUS_WORD answer direct SFR accesses locally
    always_comb begin
        local_hit = to_sfr_q && (eaddr_q == `DMB_ADDR_SP || eaddr_q == `DMB_ADDR_PSW);
        local_rd  = (eaddr_q == `DMB_ADDR_SP) ? stack_top_pointer_q : processor_status_word_q;
    end

    // Byte seen by the read state
    assign byte_rd = !to_sfr_q ? ram_rdata : (local_hit ? local_rd : sfr_rdata);

    // One select line per bit of the held byte
    for (genvar g = 0; g < 8; g++) begin : g_bit
        assign bit_sel[g]    = (bitpos_q == 3'(g));
        assign bit_merged[g] = bit_sel[g] ? cur_q.wbit : byte_rd[g];
    end

    // Bit writes merge into the byte just read
    always_comb begin
        byte_wr = cur_q.wdata;
        if (cur_q.is_bit) begin
            byte_wr = bit_merged;
        end
    end

    // Merged byte held for the write state
    logic [7:0] wr_hold_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_hold_q <= '0;
        end else if (st_q == DMB_ST_READ) begin
            wr_hold_q <= byte_wr;
        end
    end

    logic [7:0] final_wr;
    assign final_wr = is_push ? cur_q.wdata : wr_hold_q;

    assign ram_we    = (st_q == DMB_ST_WRITE) && !to_sfr_q;
    assign ram_waddr = eaddr_q;
    assign ram_wdata = final_wr;

    // One store serves lower and upper halves
    dmb_ram u_ram (
        .core_clk (core_clk),
        .raddr    (ram_raddr),
        .rdata    (ram_rdata),
        .we       (ram_we),
        .waddr    (ram_waddr),
        .wdata    (ram_wdata)
    );

    // External SFR port; SP and PROCESSOR_STATUS_WORD never leave the block
    always_comb begin
        sfr.sfr_rd    = (st_q == DMB_ST_READ) && to_sfr_q && !local_hit;
        sfr.sfr_wr    = (st_q == DMB_ST_WRITE) && to_sfr_q && !local_hit;
        sfr.sfr_addr  = eaddr_q;
        sfr.sfr_wdata = final_wr;
    end

    // Stack pointer: push, pop or direct write
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stack_top_pointer_q <= `DMB_SP_RESET;
        end else if (st_q == DMB_ST_WRITE && cur_q.op == DMB_OP_PUSH) begin
            stack_top_pointer_q <= eaddr_q;
        end else if (st_q == DMB_ST_READ && cur_q.op == DMB_OP_POP) begin
            stack_top_pointer_q <= stack_top_pointer_q - `DMB_ONE;
        end else if (st_q == DMB_ST_WRITE && local_hit && eaddr_q == `DMB_ADDR_SP) begin
            stack_top_pointer_q <= final_wr;
        end
    end

    // Status word: direct byte or bit writes only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            processor_status_word_q <= `DMB_PSW_RESET;
        end else if (st_q == DMB_ST_WRITE && local_hit && eaddr_q == `DMB_ADDR_PSW) begin
            processor_status_word_q <= final_wr;
        end
    end

    // Last state of every request
    assign done = (st_q == DMB_ST_WRITE) || (st_q == DMB_ST_READ && !needs_write);

    // Answer strobe one edge after the last state
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= done;
        end
    end

    // Read data held until the next pass through the read state, writes included
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_data <= '0;
            rsp_bit  <= 1'b0;
        end else if (st_q == DMB_ST_READ) begin
            rsp_data <= byte_rd;
            rsp_bit  <= byte_rd[bitpos_q];
        end
    end
endmodule // dmb_decode

`default_nettype wire

// ==== dmb_decode_props.sv ====
// Purpose: Concurrent checks on the data memory decode ports
// Assumes: Requests are only issued while the block is idle
// Notes:   Bound into every dmb_decode instance
`timescale 1ns/1ps
`default_nettype none
module dmb_decode_props
    import dmb_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst_b,
    input wire logic       req_valid,
    input wire dmb_req_s   req,
    input wire logic       rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic       rsp_bit,
    input wire dmb_sfr_s   sfr,
    input wire logic [7:0] sfr_rdata,
    input wire logic [7:0] stack_top_pointer_q,
    input wire logic [7:0] processor_status_word_q,
    input wire logic [1:0] active_bank
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire logic strobe = sfr.sfr_rd | sfr.sfr_wr;
    sp_reset_a: assert property ($rose(rst_b) |-> stack_top_pointer_q == 8'h07)
        else $error("stack pointer not 07 after reset");
    bank_sel_a: assert property (active_bank == processor_status_word_q[4:3])
        else $error("active bank differs from status bits");
    sfr_range_a: assert property (strobe |-> sfr.sfr_addr[7])
        else $error("sfr strobe below 80");
    sp_local_a: assert property (strobe |-> sfr.sfr_addr != 8'h81 && sfr.sfr_addr != 8'hd0)
        else $error("stack pointer or status word sent outside");
    push_inc_a: assert property (req_valid && req.op == DMB_OP_PUSH |->
        ##3 stack_top_pointer_q == $past(stack_top_pointer_q, 3) + 8'h01) else $error("push did not add one");
    pop_dec_a: assert property (req_valid && req.op == DMB_OP_POP |->
        ##3 stack_top_pointer_q == $past(stack_top_pointer_q, 3) - 8'h01) else $error("pop did not subtract one");
    low_rd_a: assert property (req_valid && req.op == DMB_OP_DIRECT && !req.wr && !req.addr[7]
        |=> !rsp_valid ##1 rsp_valid) else $error("direct read answer not on second edge");
    ind_ram_a: assert property (req_valid && req.op == DMB_OP_INDIRECT |-> ##1 (!strobe) [*3])
        else $error("indirect access reached sfr port");
    push_c: cover property (req_valid && req.op == DMB_OP_PUSH);
    pop_c: cover property (req_valid && req.op == DMB_OP_POP);
    sfr_wr_c: cover property (sfr.sfr_wr);
    ind_c: cover property (req_valid && req.op == DMB_OP_INDIRECT);
endmodule // dmb_decode_props
bind dmb_decode dmb_decode_props u_props (.core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid),
    .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_bit(rsp_bit), .sfr(sfr),
    .sfr_rdata(sfr_rdata), .stack_top_pointer_q(stack_top_pointer_q),
    .processor_status_word_q(processor_status_word_q), .active_bank(active_bank));
`default_nettype wire

// ==== dmb_defs.svh ====
// Purpose: Constants for the internal data memory decode block
// Assumes: Byte-wide data, 8-bit addresses
// Notes:   Included by the design modules dmb_decode and dmb_ram, not by the package
`ifndef DMB_DEFS_SVH
`define DMB_DEFS_SVH

`define DMB_BANK_LIMIT    8'h1f
`define DMB_BITRAM_BASE   8'h20
`define DMB_BITRAM_LAST   8'h2f
`define DMB_SFR_BASE      8'h80
`define DMB_ADDR_SP       8'h81
`define DMB_ADDR_PSW      8'hd0
`define DMB_SP_RESET      8'h07
`define DMB_PSW_RESET     8'h00
`define DMB_RS0_POS       3
`define DMB_RS1_POS       4
`define DMB_BITADR_SFR    8'h80
`define DMB_SFR_BITMASK   8'h07
`define DMB_RAM_DEPTH     256
`define DMB_ONE           8'h01

`endif

// ==== dmb_pkg.sv ====
// Purpose: Types shared by the data memory decode design
// Assumes: Nothing beyond the defines header
// Notes:   Access kinds come from the instruction executing
package dmb_pkg;

    typedef enum logic [2:0] {
        DMB_OP_NONE     = 3'b000,
        DMB_OP_DIRECT   = 3'b001,
        DMB_OP_INDIRECT = 3'b010,
        DMB_OP_RN       = 3'b011,
        DMB_OP_PUSH     = 3'b100,
        DMB_OP_POP      = 3'b101
    } dmb_op_e;

    typedef struct packed {
        dmb_op_e    op;
        logic       is_bit;
        logic       wr;
        logic [7:0] addr;
        logic       wbit;
        logic [7:0] wdata;
    } dmb_req_s;

    typedef struct packed {
        logic       sfr_rd;
        logic       sfr_wr;
        logic [7:0] sfr_addr;
        logic [7:0] sfr_wdata;
    } dmb_sfr_s;

endpackage

// ==== dmb_ram.sv ====
// Purpose: 256-byte internal data RAM, registered read
// Assumes: One read and one write port
// Notes:   Read data valid the cycle after the read address
`timescale 1ns/1ps
`default_nettype none
`include "dmb_defs.svh"

module dmb_ram (
    input  wire logic       core_clk,
    input  wire logic [7:0] raddr,
    output logic      [7:0] rdata,
    input  wire logic       we,
    input  wire logic [7:0] waddr,
    input  wire logic [7:0] wdata
);
    logic [7:0] mem [`DMB_RAM_DEPTH];

    always_ff @(posedge core_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        rdata <= mem[raddr];
    end
endmodule // dmb_ram

`default_nettype wire

// ==== dmb_sfr_model.sv ====
// Purpose: Peripheral register space seen through the sfr port
// Assumes: Byte registers; initial content equals the address
// Notes:   Read data is inverted outside read strobes
`timescale 1ns/1ps
`default_nettype none
module dmb_sfr_model
    import dmb_pkg::*;
(
    input  wire logic     core_clk,
    input  wire dmb_sfr_s sfr,
    output logic    [7:0] sfr_rdata
);
    logic [7:0] mem [0:255];
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = i[7:0];
    end
    // Byte store only; bit writes arrive merged
    always @(posedge core_clk) begin
        if (sfr.sfr_wr) mem[sfr.sfr_addr] <= sfr.sfr_wdata;
    end
    assign sfr_rdata = sfr.sfr_rd ? mem[sfr.sfr_addr] : ~mem[sfr.sfr_addr];
endmodule // dmb_sfr_model
`default_nettype wire
